// ===== core/cac_defs.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the converter acquire and count controller. Assumes APB byte
 addresses and a 100 MHz system clock.
*/
// Contract
// - Time base from internal or external 10 MHz
// - Gate counts reference cycles, input counted inside
// - Select, clear, one gate, read after end
// - Multiplier passes, doubles or applies DC bias
// - Flag when IF amplitude exceeds input amplitude
// - Oscillator 400 to 500 MHz, 50 kHz steps
// - Preselector DAC gives 2 MHz resolution
// - IF threshold shown; guarded arm needs acquisition
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH

`define CAC_ADDR_CTRL 8'h00
`define CAC_ADDR_CMD 8'h04
`define CAC_ADDR_STATUS 8'h08
`define CAC_ADDR_COUNT 8'h0C
`define CAC_ADDR_OSC 8'h10
`define CAC_ADDR_FILTER 8'h14
`define CAC_ADDR_LIMITS 8'h18

`define CAC_CMD_CLEAR 0
`define CAC_CMD_ARM 1
`define CAC_ST_DONE 1
`define CAC_ST_NOSIG 4
`define CAC_ST_HIT 5
`define CAC_ST_REFUSED 6

`define CAC_CTRL_RST 9'h000
`define CAC_LOW_RST 14'h01F4
`define CAC_HIGH_RST 14'h2328

`define CAC_CLK_NS 10
`define CAC_REF_MHZ 10
`define CAC_GATE_1S_MS 1000
`define CAC_GATE_100MS_MS 100
`define CAC_GATE_10MS_MS 10
`define CAC_GATE_1MS_MS 1
`define CAC_OSC_STEP_MAX 11'h7D0
`define CAC_SEARCH_STEP 14'h0020
`define CAC_SETTLE_NS 2000

`endif

// ===== core/cac_pkg.sv
/*
 Types of the converter acquire and count controller.
 Assumes cac_defs.svh supplies the numeric constants.
*/
package cac_pkg;
  // Gate sequencer, one-hot
  typedef enum logic [2:0] {
    G_IDLE = 3'b001,
    G_ARMED = 3'b010,
    G_OPEN = 3'b100
  } cac_gate_t;

  // Preselector search sequencer, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_SETTLE = 4'b0010,
    S_SAMPLE = 4'b0100,
    S_HIT = 4'b1000
  } cac_search_t;

  // Oscillator multiplier modes
  typedef enum logic [1:0] {
    MUL_PASS = 2'h0,
    MUL_DOUBLE = 2'h1,
    MUL_BIAS = 2'h2
  } cac_mul_t;

  // Control register layout, bit 0 first from the right
  typedef struct packed {
    logic ifGuard;
    logic searchEn;
    logic [1:0] multMode;
    logic [1:0] srcSel;
    logic [1:0] gateSel;
    logic refExt;
  } cac_ctrl_t;
endpackage

// ===== core/cac_acquire_ctrl.sv
/*
 Converter acquire and count controller: reference selection, gate
 generator, count chain, oscillator and preselector settings, search
 sweep and detector flags, reached over APB.
 Assumes pin inputs are asynchronous and the APB master is on clk.
*/
`timescale 1ns/1ps
`include "cac_defs.svh"

module cac_acquire_ctrl #(
  parameter int REF_PER_MS = `CAC_REF_MHZ * 1000,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference and count sources
  input wire logic refInt,
  input wire logic refExt,
  input wire logic [3:0] sigIn,
  // Detectors
  input wire logic [7:0] ifAmp,
  input wire logic [7:0] rfAmp,
  input wire logic ifThresh,
  input wire logic rfThresh,
  // Converter controls
  output logic gateOpen,
  output logic [10:0] oscStep,
  output logic [13:0] preselectorCenter,
  output logic mulPass,
  output logic mulDouble,
  output logic mulBiasOnly,
  output logic cmpFlag
);

  localparam int SETTLE_CYC = (`CAC_SETTLE_NS + `CAC_CLK_NS - 1) / `CAC_CLK_NS;

  // Gate length must fit the 24-bit reference counter
  if (REF_PER_MS < 1 || REF_PER_MS > 16000 || CNT_W < 8 || CNT_W > 32) begin : g_chk
    $error("cac_acquire_ctrl: unsupported parameter values");
  end

  // Reference cycles for a gate selection
  function automatic logic [23:0] gateLen(input logic [1:0] sel);
    int ms;
    case (sel)
      2'h0: ms = `CAC_GATE_1S_MS;
      2'h1: ms = `CAC_GATE_100MS_MS;
      2'h2: ms = `CAC_GATE_10MS_MS;
      default: ms = `CAC_GATE_1MS_MS;
    endcase
    return 24'(ms * REF_PER_MS);
  endfunction

  // Mapped register check
  function automatic logic mapped(input logic [7:0] a);
    return a == `CAC_ADDR_CTRL || a == `CAC_ADDR_CMD || a == `CAC_ADDR_STATUS ||
      a == `CAC_ADDR_COUNT || a == `CAC_ADDR_OSC || a == `CAC_ADDR_FILTER ||
      a == `CAC_ADDR_LIMITS;
  endfunction

  // Pin synchronisers, third stage only for edge detection
  logic [1:0] refS1, refS2, refS3;
  logic [3:0] sigS1, sigS2, sigS3;
  logic [7:0] ifAmpS1, ifAmpS2, rfAmpS1, rfAmpS2;
  logic ifThS1, ifThreshS, rfThS1, rfThreshS;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      refS1 <= 2'h0;
      refS2 <= 2'h0;
      refS3 <= 2'h0;
      sigS1 <= 4'h0;
      sigS2 <= 4'h0;
      sigS3 <= 4'h0;
      ifAmpS1 <= 8'h00;
      ifAmpS2 <= 8'h00;
      rfAmpS1 <= 8'h00;
      rfAmpS2 <= 8'h00;
      ifThS1 <= 1'b0;
      ifThreshS <= 1'b0;
      rfThS1 <= 1'b0;
      rfThreshS <= 1'b0;
    end else begin
      refS1 <= {refExt, refInt};
      refS2 <= refS1;
      refS3 <= refS2;
      sigS1 <= sigIn;
      sigS2 <= sigS1;
      sigS3 <= sigS2;
      ifAmpS1 <= ifAmp;
      ifAmpS2 <= ifAmpS1;
      rfAmpS1 <= rfAmp;
      rfAmpS2 <= rfAmpS1;
      ifThS1 <= ifThresh;
      ifThreshS <= ifThS1;
      rfThS1 <= rfThresh;
      rfThreshS <= rfThS1;
    end
  end

  cac_pkg::cac_ctrl_t ctrl, next_ctrl;
  logic refTick, sigEdge, wrEn, clrCmd, armCmd;
  assign refTick = ctrl.refExt ? (refS2[1] & ~refS3[1]) : (refS2[0] & ~refS3[0]);
  assign sigEdge = sigS2[ctrl.srcSel] & ~sigS3[ctrl.srcSel];
  assign wrEn = psel & penable & pready & pwrite & ~pslverr;
  assign clrCmd = wrEn && paddr == `CAC_ADDR_CMD && pwdata[`CAC_CMD_CLEAR];
  assign armCmd = wrEn && paddr == `CAC_ADDR_CMD && pwdata[`CAC_CMD_ARM];

  // Gate generator and count chain
  cac_pkg::cac_gate_t gst, next_gst;
  logic [23:0] gateCnt, next_gateCnt;
  logic [CNT_W-1:0] count, next_count;
  logic stsDone, next_done, refused, next_refused, next_gateOpen;
  always_comb begin
    next_gst = gst;
    next_gateCnt = gateCnt;
    next_count = count;
    next_done = clrCmd ? 1'b0 : stsDone;
    next_refused = refused;
    if (wrEn && paddr == `CAC_ADDR_STATUS) begin
      if (pwdata[`CAC_ST_DONE]) next_done = 1'b0;
      if (pwdata[`CAC_ST_REFUSED]) next_refused = 1'b0;
    end
    case (gst)
      cac_pkg::G_IDLE: begin
        // guarded arm is refused without IF acquisition
        if (armCmd && ctrl.ifGuard && !ifThreshS) begin
          next_refused = 1'b1;
        end else if (armCmd) begin
          next_gst = cac_pkg::G_ARMED;
        end
      end
      cac_pkg::G_ARMED: begin
        // gate opens on a reference edge
        if (refTick) begin
          next_gst = cac_pkg::G_OPEN;
          next_gateCnt = gateLen(ctrl.gateSel) - 24'h000001;
        end
      end
      cac_pkg::G_OPEN: begin
        if (sigEdge) next_count = count + 1'b1;
        if (refTick) begin
          if (gateCnt == 24'h000000) begin
            next_gst = cac_pkg::G_IDLE;
            next_done = 1'b1;
          end else begin
            next_gateCnt = gateCnt - 24'h000001;
          end
        end
      end
      default: next_gst = cac_pkg::G_IDLE;
    endcase
    if (clrCmd) next_count = '0;
    next_gateOpen = next_gst == cac_pkg::G_OPEN;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gst <= cac_pkg::G_IDLE;
      gateCnt <= 24'h000000;
      count <= '0;
      stsDone <= 1'b0;
      refused <= 1'b0;
      gateOpen <= 1'b0;
    end else begin
      gst <= next_gst;
      gateCnt <= next_gateCnt;
      count <= next_count;
      stsDone <= next_done;
      refused <= next_refused;
      gateOpen <= next_gateOpen;
    end
  end

  // Search sweep and converter settings
  cac_pkg::cac_search_t sst, next_sst;
  logic [7:0] settle, next_settle;
  logic [13:0] lowLim, highLim, next_low, next_high, next_presel, stepUp;
  logic [10:0] next_osc;
  logic noSig, next_noSig, hit, next_hit;
  assign stepUp = preselectorCenter + `CAC_SEARCH_STEP;
  always_comb begin
    next_ctrl = ctrl;
    next_osc = oscStep;
    next_presel = preselectorCenter;
    next_low = lowLim;
    next_high = highLim;
    next_sst = sst;
    next_settle = settle;
    next_noSig = noSig;
    next_hit = hit;
    if (wrEn && paddr == `CAC_ADDR_CTRL) next_ctrl = cac_pkg::cac_ctrl_t'(pwdata[8:0]);
    // 50 kHz steps above 400 MHz
    if (wrEn && paddr == `CAC_ADDR_OSC && pwdata[10:0] <= `CAC_OSC_STEP_MAX) begin
      next_osc = pwdata[10:0];
    end
    if (wrEn && paddr == `CAC_ADDR_FILTER && sst == cac_pkg::S_IDLE) begin
      next_presel = pwdata[13:0];
    end
    if (wrEn && paddr == `CAC_ADDR_LIMITS) begin
      next_low = pwdata[13:0];
      next_high = pwdata[29:16];
    end
    if (wrEn && paddr == `CAC_ADDR_STATUS) begin
      if (pwdata[`CAC_ST_NOSIG]) next_noSig = 1'b0;
      if (pwdata[`CAC_ST_HIT]) next_hit = 1'b0;
    end
    case (sst)
      cac_pkg::S_IDLE: begin
        if (ctrl.searchEn) begin
          next_presel = lowLim;
          next_settle = 8'(SETTLE_CYC - 1);
          next_sst = cac_pkg::S_SETTLE;
        end
      end
      cac_pkg::S_SETTLE: begin
        if (settle == 8'h00) next_sst = cac_pkg::S_SAMPLE;
        else next_settle = settle - 8'h01;
      end
      cac_pkg::S_SAMPLE: begin
        next_settle = 8'(SETTLE_CYC - 1);
        if (rfThreshS) begin
          next_hit = 1'b1;
          next_sst = cac_pkg::S_HIT;
        end else if (stepUp > highLim || stepUp < preselectorCenter) begin
          next_noSig = 1'b1;
          next_presel = lowLim;
          next_sst = cac_pkg::S_SETTLE;
        end else begin
          next_presel = stepUp;
          next_sst = cac_pkg::S_SETTLE;
        end
      end
      cac_pkg::S_HIT: begin
        // Software owns the filter until it clears the hit flag
        if (wrEn && paddr == `CAC_ADDR_FILTER) next_presel = pwdata[13:0];
        if (!hit) begin
          next_sst = cac_pkg::S_SAMPLE;
        end
      end
      default: next_sst = cac_pkg::S_IDLE;
    endcase
    if (!ctrl.searchEn) next_sst = cac_pkg::S_IDLE;
    if (sst == cac_pkg::S_SAMPLE && rfThreshS) next_hit = 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= cac_pkg::cac_ctrl_t'(`CAC_CTRL_RST);
      oscStep <= 11'h000;
      preselectorCenter <= 14'h0000;
      lowLim <= `CAC_LOW_RST;
      highLim <= `CAC_HIGH_RST;
      sst <= cac_pkg::S_IDLE;
      settle <= 8'h00;
      noSig <= 1'b0;
      hit <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      oscStep <= next_osc;
      preselectorCenter <= next_presel;
      lowLim <= next_low;
      highLim <= next_high;
      sst <= next_sst;
      settle <= next_settle;
      noSig <= next_noSig;
      hit <= next_hit;
    end
  end

  // Multiplier select and amplitude comparator
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mulPass <= 1'b1;
      mulDouble <= 1'b0;
      mulBiasOnly <= 1'b0;
      cmpFlag <= 1'b0;
    end else begin
      mulPass <= ctrl.multMode == cac_pkg::MUL_PASS;
      mulDouble <= ctrl.multMode == cac_pkg::MUL_DOUBLE;
      mulBiasOnly <= ctrl.multMode[1];
      cmpFlag <= ifAmpS2 > rfAmpS2;
    end
  end

  // APB: answer in the cycle after setup
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      if (paddr == `CAC_ADDR_CTRL) next_prdata = {23'h0, ctrl};
      else if (paddr == `CAC_ADDR_STATUS) begin
        next_prdata = {25'h0, refused, hit, noSig, ifThreshS, cmpFlag, stsDone, gateOpen};
      end else if (paddr == `CAC_ADDR_COUNT) next_prdata = 32'(count);
      else if (paddr == `CAC_ADDR_OSC) next_prdata = {21'h0, oscStep};
      else if (paddr == `CAC_ADDR_FILTER) next_prdata = {18'h0, preselectorCenter};
      else if (paddr == `CAC_ADDR_LIMITS) next_prdata = {2'h0, highLim, 2'h0, lowLim};
      else next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  AST_GATE_COUNT: assert property ((gst != cac_pkg::G_OPEN && !clrCmd) |=> $stable(count))
    else $error("count moved outside gate");
  AST_REF_TICK: assert property ((gst == cac_pkg::G_OPEN && !refTick) |=> $stable(gateCnt))
    else $error("gate counter moved without reference edge");
  AST_DONE: assert property ($fell(gateOpen) |-> stsDone || $past(clrCmd))
    else $error("gate ended without done");
  AST_CLEAR: assert property (clrCmd |=> count == '0)
    else $error("clear did not zero count");
  AST_MUL: assert property (##1 $onehot({mulPass, mulDouble, mulBiasOnly}))
    else $error("multiplier state not one-hot");
  AST_CMP: assert property (##1 cmpFlag == $past(ifAmpS2 > rfAmpS2))
    else $error("comparator flag wrong");
  AST_OSC: assert property (oscStep <= `CAC_OSC_STEP_MAX)
    else $error("oscillator step out of range");
  AST_STEP: assert property ((sst == cac_pkg::S_SAMPLE && ctrl.searchEn && !rfThreshS &&
    stepUp <= highLim && stepUp >= preselectorCenter) |=>
    preselectorCenter == $past(stepUp) ##1 sst == cac_pkg::S_SETTLE)
    else $error("search step wrong");
  AST_NOSIG: assert property ((sst == cac_pkg::S_SAMPLE && !rfThreshS && stepUp > highLim)
    |=> noSig && preselectorCenter == $past(lowLim))
    else $error("empty sweep not flagged");
  AST_GUARD: assert property ((armCmd && ctrl.ifGuard && !ifThreshS && gst == cac_pkg::G_IDLE)
    |=> gst == cac_pkg::G_IDLE && refused)
    else $error("guarded arm not refused");
  AST_HIT: assert property ((sst == cac_pkg::S_SAMPLE && ctrl.searchEn && rfThreshS)
    |=> sst == cac_pkg::S_HIT && hit)
    else $error("trip did not pause search");

  COV_GATE: cover property ($rose(gateOpen) ##[1:1000] $fell(gateOpen));
  COV_NOSIG: cover property ($rose(noSig));
  COV_HIT: cover property ($rose(hit));
  COV_REFUSE: cover property ($rose(refused));

endmodule

// ===== verif/cac_front_model.sv
/*
 Converter front-end model: reference oscillators, count sources and
 the search threshold detector. Assumes the bench drives extOn and hitCode.
*/
`timescale 1ns/1ps

module cac_front_model (
  // Controls from the bench
  input wire logic extOn,
  input wire logic [13:0] hitCode,
  // Preselector setting from the design
  input wire logic [13:0] preselectorCenter,
  // Pins toward the design
  output logic refInt,
  output logic refExt,
  output logic [3:0] sigIn,
  output logic rfThresh
);
  initial begin
    refInt = 1'b0;
    #3;
    forever #50 refInt = ~refInt;
  end
  // External reference stands still while unplugged
  initial begin
    refExt = 1'b0;
    forever #50 refExt = extOn ? ~refExt : 1'b0;
  end
  // sources of 40 to 100 ns period
  for (genvar k = 0; k < 4; k++) begin : g_src
    initial begin
      sigIn[k] = 1'b0;
      forever #(20 + 10 * k) sigIn[k] = ~sigIn[k];
    end
  end
  // detector trips at one filter code
  assign rfThresh = (preselectorCenter == hitCode);
endmodule

// ===== verif/tb.sv
/*
 Testbench for the acquire and count controller, an APB master driving
 register sequences. Assumes the front-end model supplies the pins.
*/
`timescale 1ns/1ps
`include "cac_defs.svh"

module tb;
  // Bench state
  logic clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic ifThresh, rfThresh, extOn, refInt, refExt, gateOpen;
  logic mulPass, mulDouble, mulBiasOnly, cmpFlag;
  logic [7:0] paddr, ifAmp, rfAmp;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] sigIn;
  logic [10:0] oscStep;
  logic [13:0] preselectorCenter, hitCode;
  int nMismatch, checked, cycles, n;
  int ms[4] = '{`CAC_GATE_1S_MS, `CAC_GATE_100MS_MS, `CAC_GATE_10MS_MS, `CAC_GATE_1MS_MS};

  cac_acquire_ctrl #(.REF_PER_MS(1)) dut_u (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .refInt(refInt), .refExt(refExt), .sigIn(sigIn),
    .ifAmp(ifAmp), .rfAmp(rfAmp), .ifThresh(ifThresh), .rfThresh(rfThresh),
    .gateOpen(gateOpen), .oscStep(oscStep), .preselectorCenter(preselectorCenter),
    .mulPass(mulPass), .mulDouble(mulDouble), .mulBiasOnly(mulBiasOnly), .cmpFlag(cmpFlag));
  cac_front_model model_u (.extOn(extOn), .hitCode(hitCode),
    .preselectorCenter(preselectorCenter), .refInt(refInt), .refExt(refExt),
    .sigIn(sigIn), .rfThresh(rfThresh));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nMismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (nMismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      nMismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic cmp_near(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if ($isunknown(g) || g + 2 < x || g > x + 2) begin
      nMismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One APB transfer, released at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits for pready; only the hang guard ends a stuck transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  // Read STATUS until a bit is set
  task automatic poll(input int b, input int lim);
    int i;
    i = 0;
    do begin
      rd(`CAC_ADDR_STATUS);
      i++;
    end while (rdat[b] !== 1'b1 && i < lim);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] g, s, m, input logic se, ig, ex);
    return {23'h000000, ig, se, m, s, g, ex};
  endfunction

  // oscillator step for a filter center in MHz
  function automatic int osc_for(input int ctr);
    int nh, f;
    nh = (ctr - 125 + 499) / 500;
    if (nh < 1) nh = 1;
    f = (ctr - 125) / nh;
    if (f < 400) f = (ctr + 125) / nh;
    return (f - 400) * 20;
  endfunction

  // One measurement: source g, gate g, width and count checked
  task automatic gate(input int g);
    int lim;
    wr(`CAC_ADDR_CTRL, ctl(g, g, 2'h0, 1'b0, 1'b0, 1'b0));
    wr(`CAC_ADDR_CMD, 32'h00000001);
    rd(`CAC_ADDR_COUNT);
    cmp(rdat, 32'h00000000);
    wr(`CAC_ADDR_CMD, 32'h00000002);
    lim = 0;
    while (gateOpen !== 1'b1 && lim < 100) begin
      @(posedge clk);
      lim++;
    end
    n = 0;
    while (gateOpen === 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    cmp_near(n, ms[g] * 10);
    poll(`CAC_ST_DONE, 20);
    cmp(rdat[1], 32'h00000001);
    rd(`CAC_ADDR_COUNT);
    cmp_near(rdat, ms[g] * 100 / (40 + 20 * g));
    // Count to source frequency in MHz, gate of ms * 100 ns
    cmp_near(rdat * 10 / ms[g], 1000 / (40 + 20 * g));
    wr(`CAC_ADDR_STATUS, 32'h00000002);
    rd(`CAC_ADDR_STATUS);
    cmp(rdat & 32'h00000003, 32'h00000000);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ifAmp = 8'h00;
    rfAmp = 8'h00;
    ifThresh = 1'b0;
    extOn = 1'b0;
    hitCode = 14'h3FFF;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    cmp({29'h0, mulBiasOnly, mulDouble, mulPass}, 32'h00000001);
    rd(`CAC_ADDR_CTRL);
    cmp(rdat, 32'h00000000);
    rd(`CAC_ADDR_LIMITS);
    cmp(rdat, 32'h232801F4);
    rd(8'h1C);
    cmp({rerr, rdat[30:0]}, 32'h80000000);
    for (int m = 0; m < 4; m++) begin
      wr(`CAC_ADDR_CTRL, ctl(2'h0, 2'h0, m, 1'b0, 1'b0, 1'b0));
      repeat (2) @(posedge clk);
      cmp({mulBiasOnly, mulDouble, mulPass}, m == 0 ? 1 : (m == 1 ? 2 : 4));
    end
    // Lower converter, second harmonic of 425 MHz
    wr(`CAC_ADDR_CTRL, ctl(2'h0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0));
    wr(`CAC_ADDR_OSC, (425 - 400) * 20);
    @(posedge clk);
    cmp({mulDouble, oscStep}, {1'b1, 11'h1F4});
    // Microwave oscillator steps from a 328 MHz filter center
    wr(`CAC_ADDR_OSC, osc_for(328));
    wr(`CAC_ADDR_OSC, osc_for(328) + 20);
    rd(`CAC_ADDR_OSC);
    cmp(rdat, 32'h00000438);
    wr(`CAC_ADDR_OSC, osc_for(328) - (135 - 125) * 20);
    wr(`CAC_ADDR_OSC, osc_for(328) - 200 + 20 * 20);
    rd(`CAC_ADDR_OSC);
    cmp(rdat, 32'h000004EC);
    wr(`CAC_ADDR_OSC, osc_for(340));
    rd(`CAC_ADDR_OSC);
    cmp(rdat, 32'h00000514);
    wr(`CAC_ADDR_OSC, 32'h000007D0);
    wr(`CAC_ADDR_OSC, 32'h000007D1);
    rd(`CAC_ADDR_OSC);
    cmp({rdat[31:11], oscStep}, 32'h000007D0);
    wr(`CAC_ADDR_FILTER, 32'h00001234);
    @(posedge clk);
    cmp({18'h0, preselectorCenter}, 32'h00001234);
    ifAmp <= 8'h81;
    rfAmp <= 8'h80;
    repeat (6) @(posedge clk);
    rd(`CAC_ADDR_STATUS);
    cmp({rdat[2], cmpFlag}, 32'h00000003);
    rfAmp <= 8'h81;
    repeat (6) @(posedge clk);
    cmp(cmpFlag, 32'h00000000);
    for (int g = 0; g < 4; g++) begin
      gate(g);
    end
    wr(`CAC_ADDR_CTRL, ctl(2'h3, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0));
    wr(`CAC_ADDR_CMD, 32'h00000003);
    repeat (30) @(posedge clk);
    rd(`CAC_ADDR_STATUS);
    cmp(rdat & 32'h0000004B, 32'h00000040);
    wr(`CAC_ADDR_STATUS, 32'h00000040);
    ifThresh <= 1'b1;
    repeat (5) @(posedge clk);
    wr(`CAC_ADDR_CMD, 32'h00000003);
    poll(`CAC_ST_DONE, 100);
    cmp(rdat & 32'h0000004A, 32'h0000000A);
    wr(`CAC_ADDR_CTRL, ctl(2'h3, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1));
    wr(`CAC_ADDR_CMD, 32'h00000003);
    repeat (50) @(posedge clk);
    cmp(gateOpen, 32'h00000000);
    extOn <= 1'b1;
    poll(`CAC_ST_DONE, 100);
    cmp(rdat[1], 32'h00000001);
    wr(`CAC_ADDR_LIMITS, {2'b00, 14'd200, 2'b00, 14'd100});
    hitCode <= 14'd164;
    wr(`CAC_ADDR_CTRL, ctl(2'h3, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0));
    poll(`CAC_ST_HIT, 400);
    cmp(preselectorCenter, 32'd164);
    // Centering: both edges, then the average
    wr(`CAC_ADDR_FILTER, 32'h000000A2);
    wr(`CAC_ADDR_FILTER, 32'h000000A6);
    wr(`CAC_ADDR_FILTER, (162 + 166) / 2);
    @(posedge clk);
    cmp(preselectorCenter, 32'h000000A4);
    hitCode <= 14'h3FFF;
    wr(`CAC_ADDR_STATUS, 32'h00000020);
    poll(`CAC_ST_NOSIG, 400);
    cmp({rdat[5], 17'h0, preselectorCenter}, 32'd100);
    give_verdict();
  end
endmodule
